// ==== always_on_wake_config_pkg.sv ====
// constants, types and state layout of the wake configuration block
// What this block does
// - retention array keeps contents while supply present
// - sleep entry saves user configuration automatically
// - wake restores saved user configuration when bit 6 is set
// - wake config is 16 bits, resets zero
// - bit 0 starts sensor conversions on wake
// - conversion results land in sensor readback
// - bit 1 enters receive on wake
// - bit 3 loads identifier from otp
// - register sub-offsets decode as mapped
// - bit 6 restores, else configuration defaults
// - bit 7 selects long parameter set
// - bit 8 keeps sleep controls at wake
// - bit 11 loads edge microcode on wake
package always_on_wake_config_pkg;

	// ****************************************************************
	// register sub-offsets (byte addresses inside the register file)
	// ****************************************************************
	localparam logic [7:0] OFS_WAKE_CFG_LO   = 8'h00;
	localparam logic [7:0] OFS_WAKE_CFG_HI   = 8'h01;
	localparam logic [7:0] OFS_COMMAND       = 8'h02;
	localparam logic [7:0] OFS_READ_RESULT   = 8'h03;
	localparam logic [7:0] OFS_ACCESS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_RESERVED      = 8'h05;
	localparam logic [7:0] OFS_CFG_ZERO      = 8'h06;
	localparam logic [7:0] OFS_CFG_ONE       = 8'h0a;
	localparam int         CFG_ZERO_BYTES    = 4;
	localparam int         CFG_ONE_BYTES     = 2;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int WAKE_RUN_SENSOR_ADC_BIT        = 0;
	localparam int WAKE_ENTER_RECEIVE_BIT         = 1;
	localparam int WAKE_LOAD_IDENTIFIER_BIT       = 3;
	localparam int WAKE_RESTORE_CONFIG_BIT        = 6;
	localparam int WAKE_SELECT_LONG_PARAM_SET_BIT = 7;
	localparam int KEEP_SLEEP_CONTROLS_BIT        = 8;
	localparam int WAKE_LOAD_EDGE_MICROCODE_BIT   = 11;
	localparam int CMD_RESTORE_BIT                = 0;
	localparam int CMD_SAVE_BIT                   = 1;
	localparam int CMD_UPLOAD_BIT                 = 2;
	localparam int CMD_DIRECT_READ_BIT            = 3;
	localparam int CMD_DIRECT_ENABLE_BIT          = 7;
	localparam logic [15:0] WAKE_CFG_RESET        = 16'h0000;
	localparam logic [7:0]  COMMAND_RESET         = 8'h00;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int CFG_BYTES   = 16;
	localparam int CFG_BITS    = CFG_BYTES * 8;
	localparam int ID_BITS     = 64;
	localparam int SENSOR_BITS = 16;

	typedef enum logic [2:0] {
		S_IDLE,
		S_SAVE,
		S_RESTORE,
		S_OTP,
		S_ADC,
		S_EDGE,
		S_FINISH
	} state_e;

	typedef struct packed {
		state_e                          st;
		logic                            waking;
		logic [3:0]                      idx;
		logic [15:0]                     wcfg;
		logic [7:0]                      cmd;
		logic [7:0]                      rdat;
		logic [7:0]                      addr;
		logic [31:0]                     cfg0;
		logic [15:0]                     cfg1;
		logic [CFG_BYTES-1:0][7:0]       mem;
		logic [CFG_BITS-1:0]             ucfg;
		logic [SENSOR_BITS-1:0]          sensor;
		logic [ID_BITS-1:0]              ident;
		logic [7:0]                      rdata;
		logic                            long_param;
		logic                            ucfg_load;
		logic                            ucfg_default;
		logic                            adc_start;
		logic                            otp_req;
		logic                            edge_req;
		logic                            rx_go;
		logic                            sleep_clr;
		logic                            sleep_ready;
		logic                            wake_done;
	} state_s;

endpackage

// ==== always_on_wake_config.sv ====
// retention-domain wake configuration, save/restore and wake sequencer
`timescale 1ns/1ps
`default_nettype none
module always_on_wake_config
	import always_on_wake_config_pkg::*;
(
	// clock and power-on reset of the retention supply
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	// host register access, already decoded from the serial link
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	input  wire logic [7:0]             reg_addr_i,
	input  wire logic [7:0]             reg_wdata_i,
	output logic      [7:0]             reg_rdata_o,
	// power state events
	input  wire logic                   sleep_enter_i,
	input  wire logic                   wake_i,
	output logic                        sleep_ready_o,
	output logic                        wake_done_o,
	output logic                        busy_o,
	// user configuration registers of the host interface
	input  wire logic [CFG_BITS-1:0]    user_cfg_i,
	output logic      [CFG_BITS-1:0]    user_cfg_o,
	output logic                        user_cfg_load_o,
	output logic                        user_cfg_default_o,
	// temperature and voltage converters
	output logic                        adc_start_o,
	input  wire logic                   adc_done_i,
	input  wire logic [7:0]             adc_temp_i,
	input  wire logic [7:0]             adc_volt_i,
	output logic      [SENSOR_BITS-1:0] sensor_readback_o,
	// identifier load from otp
	output logic                        otp_id_req_o,
	input  wire logic                   otp_id_ack_i,
	input  wire logic [ID_BITS-1:0]     otp_id_i,
	output logic      [ID_BITS-1:0]     identifier_o,
	// wake actions towards the rest of the radio
	output logic                        enter_receive_o,
	output logic                        long_param_set_o,
	output logic                        clear_sleep_controls_o,
	output logic                        edge_code_load_o,
	input  wire logic                   edge_code_done_i
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// byte i of the flat user configuration vector
	function automatic logic [7:0] cfg_byte(input logic [CFG_BITS-1:0] v, input logic [3:0] i);
		cfg_byte = v[{i, 3'b000} +: 8];
	endfunction

	// next wake step after the given one, skipping disabled actions
	function automatic state_e wake_step(input logic [15:0] w, input state_e from);
		if (from < S_OTP && w[WAKE_LOAD_IDENTIFIER_BIT])
			wake_step = S_OTP;
		else if (from < S_ADC && w[WAKE_RUN_SENSOR_ADC_BIT])
			wake_step = S_ADC;
		else if (from < S_EDGE && w[WAKE_LOAD_EDGE_MICROCODE_BIT])
			wake_step = S_EDGE;
		else
			wake_step = S_FINISH;
	endfunction

	state_s r;
	state_s n;
	logic   wake_go;
	logic   sleep_go;
	logic   wcfg_long;
	logic   wcfg_keep;

	assign wake_go   = (r.st == S_IDLE) && wake_i;
	assign sleep_go  = (r.st == S_IDLE) && !wake_i && sleep_enter_i;
	assign wcfg_long = r.wcfg[WAKE_SELECT_LONG_PARAM_SET_BIT];
	assign wcfg_keep = r.wcfg[KEEP_SLEEP_CONTROLS_BIT];

	// ****************************************************************
	// next state
	// ****************************************************************

	// command bits clear as taken; a host write in the same cycle wins
	always_comb
	begin
		logic [7:0] cmd_clr;
		logic [7:0] cmd_set;
		cmd_clr = 8'h00;
		cmd_set = 8'h00;
		n = r;
		n.ucfg_load    = 1'b0;
		n.ucfg_default = 1'b0;
		n.rx_go        = 1'b0;
		n.sleep_clr    = 1'b0;
		n.sleep_ready  = 1'b0;
		n.wake_done    = 1'b0;

		// register writes, byte wide at the documented sub-offsets
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				OFS_WAKE_CFG_LO: n.wcfg[7:0]  = reg_wdata_i;
				OFS_WAKE_CFG_HI: n.wcfg[15:8] = reg_wdata_i;
				OFS_COMMAND:     cmd_set      = reg_wdata_i;
				OFS_ACCESS_ADDR: n.addr       = reg_wdata_i;
				OFS_CFG_ZERO:    n.cfg0[7:0]   = reg_wdata_i;
				OFS_CFG_ZERO + 8'h01: n.cfg0[15:8]  = reg_wdata_i;
				OFS_CFG_ZERO + 8'h02: n.cfg0[23:16] = reg_wdata_i;
				OFS_CFG_ZERO + 8'h03: n.cfg0[31:24] = reg_wdata_i;
				OFS_CFG_ONE:          n.cfg1[7:0]   = reg_wdata_i;
				OFS_CFG_ONE + 8'h01:  n.cfg1[15:8]  = reg_wdata_i;
				default: ; // read-only, reserved and unmapped writes drop
			endcase
		end

		// read data, registered; reserved and unmapped read zero
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFS_WAKE_CFG_LO:      n.rdata = r.wcfg[7:0];
				OFS_WAKE_CFG_HI:      n.rdata = r.wcfg[15:8];
				OFS_COMMAND:          n.rdata = r.cmd;
				OFS_READ_RESULT:      n.rdata = r.rdat;
				OFS_ACCESS_ADDR:      n.rdata = r.addr;
				OFS_CFG_ZERO:         n.rdata = r.cfg0[7:0];
				OFS_CFG_ZERO + 8'h01: n.rdata = r.cfg0[15:8];
				OFS_CFG_ZERO + 8'h02: n.rdata = r.cfg0[23:16];
				OFS_CFG_ZERO + 8'h03: n.rdata = r.cfg0[31:24];
				OFS_CFG_ONE:          n.rdata = r.cfg1[7:0];
				OFS_CFG_ONE + 8'h01:  n.rdata = r.cfg1[15:8];
				default:              n.rdata = 8'h00;
			endcase
		end

		// sequencer; wake beats sleep, both beat pending commands
		case (r.st)
			S_IDLE:
			begin
				if (wake_i)
				begin
					n.waking     = 1'b1;
					n.long_param = r.wcfg[WAKE_SELECT_LONG_PARAM_SET_BIT];
					n.sleep_clr  = !r.wcfg[KEEP_SLEEP_CONTROLS_BIT];
					n.idx        = 4'h0;
					if (r.wcfg[WAKE_RESTORE_CONFIG_BIT])
						n.st = S_RESTORE;
					else
					begin
						n.ucfg_default = 1'b1;
						n.st = wake_step(r.wcfg, S_RESTORE);
					end
				end
				else if (sleep_enter_i)
				begin
					n.idx = 4'h0;
					n.st  = S_SAVE;
				end
				else if (r.cmd[CMD_RESTORE_BIT])
				begin
					cmd_clr[CMD_RESTORE_BIT] = 1'b1;
					n.waking = 1'b0;
					n.idx    = 4'h0;
					n.st     = S_RESTORE;
				end
				else if (r.cmd[CMD_SAVE_BIT])
				begin
					cmd_clr[CMD_SAVE_BIT] = 1'b1;
					n.idx = 4'h0;
					n.st  = S_SAVE;
				end
				else if (r.cmd[CMD_DIRECT_READ_BIT])
				begin
					// direct access needs its enable; address beyond the array reads zero
					cmd_clr[CMD_DIRECT_READ_BIT] = 1'b1;
					if (r.cmd[CMD_DIRECT_ENABLE_BIT])
						n.rdat = (r.addr < 8'(CFG_BYTES)) ? r.mem[r.addr[3:0]] : 8'h00;
				end
				// upload has no separate staging here, so it completes at once
				cmd_clr[CMD_UPLOAD_BIT] = 1'b1;
			end
			S_SAVE:
			begin
				n.mem[r.idx] = cfg_byte(user_cfg_i, r.idx);
				n.idx = r.idx + 4'h1;
				if (r.idx == 4'(CFG_BYTES - 1))
				begin
					n.sleep_ready = 1'b1;
					n.st = S_IDLE;
				end
			end
			S_RESTORE:
			begin
				n.ucfg[{r.idx, 3'b000} +: 8] = r.mem[r.idx];
				n.idx = r.idx + 4'h1;
				if (r.idx == 4'(CFG_BYTES - 1))
				begin
					n.ucfg_load = 1'b1;
					n.st = r.waking ? wake_step(r.wcfg, S_RESTORE) : S_IDLE;
				end
			end
			S_OTP:
				if (otp_id_ack_i)
				begin
					n.ident = otp_id_i;
					n.st = wake_step(r.wcfg, S_OTP);
				end
			S_ADC:
				if (adc_done_i)
				begin
					n.sensor = {adc_temp_i, adc_volt_i};
					n.st = wake_step(r.wcfg, S_ADC);
				end
			S_EDGE:
				if (edge_code_done_i)
					n.st = wake_step(r.wcfg, S_EDGE);
			S_FINISH:
			begin
				n.rx_go     = r.wcfg[WAKE_ENTER_RECEIVE_BIT];
				n.wake_done = 1'b1;
				n.waking    = 1'b0;
				n.st        = S_IDLE;
			end
			default:
				n.st = S_IDLE;
		endcase

		// request pulses fire on entry to their wait states
		n.otp_req   = (n.st == S_OTP) && (r.st != S_OTP);
		n.adc_start = (n.st == S_ADC) && (r.st != S_ADC);
		n.edge_req  = (n.st == S_EDGE) && (r.st != S_EDGE);
		n.cmd = (r.cmd & ~cmd_clr) | cmd_set;
	end

	// ****************************************************************
	// state register
	// ****************************************************************

	// reset only comes with the retention supply, so the array survives sleep
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			r <= '0;
		else
			r <= n;
	end

	// outputs straight from the state register
	assign reg_rdata_o            = r.rdata;
	assign sleep_ready_o          = r.sleep_ready;
	assign wake_done_o            = r.wake_done;
	assign busy_o                 = (r.st != S_IDLE);
	assign user_cfg_o             = r.ucfg;
	assign user_cfg_load_o        = r.ucfg_load;
	assign user_cfg_default_o     = r.ucfg_default;
	assign adc_start_o            = r.adc_start;
	assign sensor_readback_o      = r.sensor;
	assign otp_id_req_o           = r.otp_req;
	assign identifier_o           = r.ident;
	assign enter_receive_o        = r.rx_go;
	assign long_param_set_o       = r.long_param;
	assign clear_sleep_controls_o = r.sleep_clr;
	assign edge_code_load_o       = r.edge_req;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence save_run;
		(r.st == S_SAVE) [*8];
	endsequence
	sequence restore_run;
		(r.st == S_RESTORE) [*8];
	endsequence

	wcfg_reset_a: assert property (disable iff (1'b0) $rose(rstn_i) |-> r.wcfg == WAKE_CFG_RESET)
		else $error("wake config not zero after reset");
	save_walk_a: assert property (sleep_go |=> save_run ##9 (r.st == S_IDLE && sleep_ready_o))
		else $error("save sequence length wrong");
	save_data_a: assert property (r.st == S_SAVE |=> r.mem[$past(r.idx)] == cfg_byte($past(user_cfg_i), $past(r.idx)))
		else $error("saved byte mismatch");
	restore_walk_a: assert property (wake_go && r.wcfg[WAKE_RESTORE_CONFIG_BIT] |=> restore_run ##9 user_cfg_load_o)
		else $error("restore did not finish on time");
	default_cfg_a: assert property (wake_go && !r.wcfg[WAKE_RESTORE_CONFIG_BIT] |=> user_cfg_default_o && !user_cfg_load_o)
		else $error("defaults not requested on wake");
	adc_start_a: assert property (wake_go && r.wcfg[0] && r.wcfg[6:3] == 4'h0 |=> adc_start_o && r.st == S_ADC)
		else $error("converters not started on wake");
	sensor_load_a: assert property (r.st == S_ADC && adc_done_i |=> sensor_readback_o == {$past(adc_temp_i), $past(adc_volt_i)})
		else $error("sensor readback wrong");
	rx_entry_a: assert property (wake_go && r.wcfg == 16'h0002 |=> ##1 (enter_receive_o && wake_done_o))
		else $error("receive not entered on wake");
	ident_load_a: assert property (r.st == S_OTP && otp_id_ack_i |=> identifier_o == $past(otp_id_i))
		else $error("identifier not loaded");
	param_set_a: assert property (wake_go |=> long_param_set_o == $past(wcfg_long))
		else $error("parameter set select wrong");
	keep_sleep_a: assert property (wake_go |=> clear_sleep_controls_o == !$past(wcfg_keep))
		else $error("sleep control clear wrong");
	edge_load_a: assert property (wake_go && r.wcfg == 16'h0800 |=> edge_code_load_o && r.st == S_EDGE)
		else $error("edge microcode not loaded");

endmodule
`default_nettype wire

// ==== wake_peripherals_model.sv ====
// behavioural model of converters, otp and microcode loader behind the block
`timescale 1ns/1ps
`default_nettype none
module wake_peripherals_model #(
	parameter int          DELAY = 3,
	parameter logic [7:0]  TEMP  = 8'h5a,
	parameter logic [7:0]  VOLT  = 8'hc3,
	parameter logic [63:0] ID    = 64'h0123_4567_89ab_cdef // arbitrary value
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// requests from the sequencer
	input  wire logic        adc_start_i,
	input  wire logic        otp_req_i,
	input  wire logic        edge_load_i,
	// answers
	output logic             adc_done_o,
	output logic [7:0]       temp_o,
	output logic [7:0]       volt_o,
	output logic             otp_ack_o,
	output logic [63:0]      id_o,
	output logic             edge_done_o
);
	logic [3:0] adc_cnt, otp_cnt, edge_cnt;

	// *****************************************************************
	// delayed one-cycle answers
	// *****************************************************************
	// each request restarts its own countdown; done pulses when it reaches one
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			adc_cnt <= 4'h0;
			otp_cnt <= 4'h0;
			edge_cnt <= 4'h0;
		end
		else
		begin
			adc_cnt <= adc_start_i ? 4'(DELAY) : (adc_cnt != 4'h0 ? adc_cnt - 4'h1 : 4'h0);
			otp_cnt <= otp_req_i ? 4'(DELAY) : (otp_cnt != 4'h0 ? otp_cnt - 4'h1 : 4'h0);
			edge_cnt <= edge_load_i ? 4'(DELAY) : (edge_cnt != 4'h0 ? edge_cnt - 4'h1 : 4'h0);
		end
	end

	// data is only valid with its strobe; otherwise the inverse, so stale use shows
	assign adc_done_o = (adc_cnt == 4'h1);
	assign temp_o = adc_done_o ? TEMP : ~TEMP;
	assign volt_o = adc_done_o ? VOLT : ~VOLT;
	assign otp_ack_o = (otp_cnt == 4'h1);
	assign id_o = otp_ack_o ? ID : ~ID;
	assign edge_done_o = (edge_cnt == 4'h1);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the wake configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import always_on_wake_config_pkg::*;
;
	localparam logic [127:0] PAT = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
	logic                   clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0]             reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, v;
	logic                   sleep_enter_i = 1'b0, wake_i = 1'b0;
	logic                   sleep_ready_o, wake_done_o, busy_o, user_cfg_load_o, user_cfg_default_o;
	logic [CFG_BITS-1:0]    user_cfg_i = '0, user_cfg_o;
	logic                   adc_start_o, adc_done_i, otp_id_req_o, otp_id_ack_i;
	logic [7:0]             adc_temp_i, adc_volt_i;
	logic [SENSOR_BITS-1:0] sensor_readback_o;
	logic [ID_BITS-1:0]     otp_id_i, identifier_o;
	logic                   enter_receive_o, long_param_set_o, clear_sleep_controls_o;
	logic                   edge_code_load_o, edge_code_done_i;
	int                     errors = 0, samples_checked = 0, cycles = 0, n;
	int                     cnt[8];
	string                  names[8] = '{"load", "default", "adc", "otp", "edge", "rx", "clr", "long"};

	always_on_wake_config dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .sleep_enter_i(sleep_enter_i), .wake_i(wake_i),
		.sleep_ready_o(sleep_ready_o), .wake_done_o(wake_done_o), .busy_o(busy_o),
		.user_cfg_i(user_cfg_i), .user_cfg_o(user_cfg_o), .user_cfg_load_o(user_cfg_load_o),
		.user_cfg_default_o(user_cfg_default_o), .adc_start_o(adc_start_o),
		.adc_done_i(adc_done_i), .adc_temp_i(adc_temp_i), .adc_volt_i(adc_volt_i),
		.sensor_readback_o(sensor_readback_o), .otp_id_req_o(otp_id_req_o),
		.otp_id_ack_i(otp_id_ack_i), .otp_id_i(otp_id_i), .identifier_o(identifier_o),
		.enter_receive_o(enter_receive_o), .long_param_set_o(long_param_set_o),
		.clear_sleep_controls_o(clear_sleep_controls_o), .edge_code_load_o(edge_code_load_o),
		.edge_code_done_i(edge_code_done_i));

	wake_peripherals_model model (.clk_i(clk_i), .rstn_i(rstn_i), .adc_start_i(adc_start_o),
		.otp_req_i(otp_id_req_o), .edge_load_i(edge_code_load_o), .adc_done_o(adc_done_i),
		.temp_o(adc_temp_i), .volt_o(adc_volt_i), .otp_ack_o(otp_id_ack_i), .id_o(otp_id_i),
		.edge_done_o(edge_code_done_i));

	// *****************************************************************
	// clock and hang guard
	// *****************************************************************
	always #2.5 clk_i = ~clk_i;

	// whole run is well under two thousand cycles
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			give_verdict();
		end
	end

	// *****************************************************************
	// access tasks and comparison
	// *****************************************************************
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle strobe per byte, released on the following edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// data is registered, so it is picked up half a cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask

	// pulse a power event and count cycles until its completion pulse
	task automatic pulse_sleep();
		@(posedge clk_i);
		sleep_enter_i <= 1'b1;
		@(posedge clk_i);
		sleep_enter_i <= 1'b0;
		for (n = 1; n < 100; n++)
		begin
			@(negedge clk_i);
			if (n == 1) check("busy", busy_o, 1'b1);
			if (sleep_ready_o === 1'b1)
				break;
		end
	endtask

	// counts every wake action pulse, then compares against the expected table
	task automatic do_wake(input int e[8]);
		cnt = '{default: 0};
		@(posedge clk_i);
		wake_i <= 1'b1;
		@(posedge clk_i);
		wake_i <= 1'b0;
		for (int i = 0; i < 300; i++)
		begin
			@(negedge clk_i);
			cnt[0] += int'(user_cfg_load_o === 1'b1);
			cnt[1] += int'(user_cfg_default_o === 1'b1);
			cnt[2] += int'(adc_start_o === 1'b1);
			cnt[3] += int'(otp_id_req_o === 1'b1);
			cnt[4] += int'(edge_code_load_o === 1'b1);
			cnt[5] += int'(enter_receive_o === 1'b1);
			cnt[6] += int'(clear_sleep_controls_o === 1'b1);
			if (wake_done_o === 1'b1)
				break;
		end
		check("wake done", wake_done_o, 1'b1);
		cnt[7] = int'(long_param_set_o === 1'b1);
		foreach (cnt[k]) check(names[k], cnt[k], e[k]);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// *****************************************************************
	// test sequence
	// *****************************************************************
	initial
	begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(8'h00, v);
		check("wcfg lo", v, 8'h00);
		rd(8'h01, v);
		check("wcfg hi", v, 8'h00);
		// reserved bits 2,4,5,9,10 and 12..15 written as zero
		wr(8'h00, 8'hcb);
		wr(8'h01, 8'h08);
		rd(8'h00, v);
		check("wcfg lo", v, 8'hcb);
		rd(8'h01, v);
		check("wcfg hi", v, 8'h08);
		foreach (names[k])
		begin
			wr(8'h05 + 8'(k), 8'h30 + 8'(k));
			rd(8'h05 + 8'(k), v);
			check("map", v, (k == 0 || k == 7) ? 8'h00 : 8'h30 + 8'(k));
		end
		@(posedge clk_i);
		user_cfg_i <= PAT;
		pulse_sleep();
		check("save latency", n, 17);
		// live registers are lost while asleep
		user_cfg_i <= ~PAT;
		wr(8'h04, 8'h05);
		wr(8'h03, 8'h55);
		wr(8'h02, 8'h88);
		v = 8'hff;
		for (int i = 0; i < 8 && v[CMD_DIRECT_READ_BIT] !== 1'b0; i++) rd(8'h02, v);
		check("command taken", v, 8'h80);
		rd(8'h03, v);
		check("array byte", v, 8'haa);
		do_wake('{1, 0, 1, 1, 1, 1, 1, 1});
		check("restored", user_cfg_o, PAT);
		check("sensor", sensor_readback_o, 16'h5ac3);
		check("identifier", identifier_o, 64'h0123_4567_89ab_cdef);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h01);
		pulse_sleep();
		check("save latency", n, 17);
		do_wake('{0, 1, 0, 0, 0, 0, 0, 0});
		// single-action wakes, so each action is seen on its own
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h01);
		do_wake('{0, 1, 1, 0, 0, 0, 1, 0});
		wr(8'h00, 8'h02);
		do_wake('{0, 1, 0, 0, 0, 1, 1, 0});
		wr(8'h01, 8'h08);
		wr(8'h00, 8'h00);
		do_wake('{0, 1, 0, 0, 1, 0, 1, 0});
		// host save then restore; restore waits in the command byte while busy
		@(posedge clk_i);
		user_cfg_i <= ~PAT;
		wr(8'h02, 8'h02);
		wr(8'h02, 8'h05);
		repeat (40) @(posedge clk_i);
		check("command restore", user_cfg_o, ~PAT);
		rd(8'h02, v);
		check("command clear", v, 8'h80);
		give_verdict();
	end
endmodule
`default_nettype wire
